// ### common/hscc_regs.vh
// Register map, field positions and reset values of high-speed clock control
// Summary of operation
// R1 - Pins come out of reset as ports
// R2 - Unused clock pins behave as I/O ports
// R3 - External select 0, pin select 1: crystal
// R4 - Both selects 1: external clock input mode
// R5 - Halt bit 0 starts crystal oscillator
// R6 - Halt bit 0 enables external clock input
// R7 - Software waits for stabilization before use
// R8 - Software keeps pin selects while source runs
// R9 - Choice and route 1: high-speed everywhere
// R10 - High-speed main forces high-speed peripheral clock
// R11 - CPU source 0: divided main clock
// R12 - Divide codes 0-4, default 1, others refused
// R13 - Two status bits report CPU source
// R14 - Stop instruction halts high-speed source
// R15 - Software sets stabilization time before stop
// R16 - Software halts unsupported peripherals before stop
// R17 - Halt bit 1 stops crystal or input
// R18 - Software halts only off high-speed clock
// R19 - Reset starts internal oscillator, CPU uses it
// R20 - CPU source 1: subsystem clock
// R21 - Glitch-free switching, status follows actual source
`ifndef HSCC_REGS_VH
`define HSCC_REGS_VH

// Byte offsets on the register bus
`define HSCC_OFF_PIN_CTRL 8'h00
`define HSCC_OFF_OSC_CTRL 8'h04
`define HSCC_OFF_MAIN_SEL 8'h08
`define HSCC_OFF_PROC_CLK 8'h0c
`define HSCC_OFF_STAB_CNT 8'h10
`define HSCC_OFF_STAB_SEL 8'h14

// oscillator_pin_control fields
`define HSCC_BIT_CRYSTAL_PIN_EN 0
`define HSCC_BIT_EXT_INPUT_SEL 1
// main_oscillator_control fields
`define HSCC_BIT_MAIN_HALT 0
// main_clock_selection fields
`define HSCC_BIT_MAIN_ROUTE 0
`define HSCC_BIT_MAIN_CHOICE 1
`define HSCC_BIT_ON_HIGHSPEED 2
// processor_clock_control fields
`define HSCC_DIV_LSB 0
`define HSCC_DIV_MSB 2
`define HSCC_BIT_CPU_SOURCE 4
`define HSCC_BIT_ON_SUBSYSTEM 5

// Reset values and the largest allowed divide code
`define HSCC_RST_MAIN_HALT 1'h1
`define HSCC_RST_DIV 3'h1
`define HSCC_DIV_MAX 3'h4
`define HSCC_RST_STAB_SEL 3'h5

// Bus responses
`define HSCC_RESP_OKAY 2'h0
`define HSCC_RESP_SLVERR 2'h2

`endif

// ### logic/hscc_div.v
// CPU clock prescaler: divides a tick stream by a power of two
`timescale 1ns/1ps
`include "hscc_regs.vh"
module hscc_div #(
    parameter CNT_W = 4
) (
    input wire clk,
    input wire rst,
    input wire tick_in,
    input wire [2:0] ratio,
    output wire tick_out
);
    reg [CNT_W-1:0] cnt_q;
    reg [2:0] ratio_q;
    wire [CNT_W-1:0] mask;
    wire wrap;

    // Mask of the count bits that the current ratio uses
    assign mask = ~({CNT_W{1'b1}} << ratio_q);
    assign wrap = ((cnt_q & mask) == mask);
    assign tick_out = tick_in & wrap;

    // New ratio taken only at a period boundary so no pulse is cut short
    always @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q <= {CNT_W{1'b0}};
            ratio_q <= `HSCC_RST_DIV;
        end
        else if (tick_in)
        begin
            if (wrap)
            begin
                cnt_q <= {CNT_W{1'b0}};
                ratio_q <= ratio; // R21
            end
            else
            begin
                cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // hscc_div

// ### logic/hscc_top.v
// High-speed clock control with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "hscc_regs.vh"
module hscc_top (
    input wire clk,
    input wire rst,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire hs_src_tick,
    input wire ihs_tick,
    input wire sub_tick,
    input wire [7:0] stabilization_count_status,
    input wire stop_exec,
    input wire stop_release,
    output wire crystal_input_pin_port_en,
    output wire crystal_output_pin_port_en,
    output wire crystal_osc_run,
    output wire ext_clock_in_en,
    output wire ihs_osc_run,
    output wire [2:0] stabilization_time_choice,
    output wire stop_mode,
    output wire main_tick,
    output wire periph_tick,
    output wire cpu_tick,
    output wire cpu_on_highspeed_flag,
    output wire cpu_on_subsystem_flag
);
    // Software-visible control bits
    reg crystal_pin_enable_q;
    reg external_input_select_q;
    reg main_source_halt_q;
    reg main_clock_route_q;
    reg main_source_choice_q;
    reg [2:0] cpu_divide_q;
    reg cpu_source_choice_q;
    reg [2:0] stab_sel_q;
    // Clock path state
    reg stop_q;
    reg main_hs_q;
    reg cpu_sub_q;
    // Bus slave state
    reg aw_got_q;
    reg w_got_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;
    reg [31:0] rd_val;
    reg rd_ok;

    wire aw_hs;
    wire w_hs;
    wire do_write;
    wire ar_hs;
    wire wr_ok;
    wire crystal_mode;
    wire ext_mode;
    wire hs_running;
    wire hs_gated;
    wire ihs_gated;
    wire sub_gated;
    wire main_req_hs;
    wire main_src_tick;
    wire div_tick;
    wire [2:0] wr_div;

    // Pin mode decode; pin select 0 leaves both pins as ports
    assign crystal_mode = crystal_pin_enable_q & ~external_input_select_q; // R3
    assign ext_mode = crystal_pin_enable_q & external_input_select_q; // R4
    // Input pin is a port unless crystal mode; output pin unless any mode
    assign crystal_input_pin_port_en = ~crystal_mode; // R1 R2 R4
    assign crystal_output_pin_port_en = ~crystal_pin_enable_q; // R1 R2

    // Source runs only with halt clear and outside stop mode
    assign crystal_osc_run = crystal_mode & ~main_source_halt_q &
        ~stop_q; // R5 R14 R17
    assign ext_clock_in_en = ext_mode & ~main_source_halt_q &
        ~stop_q; // R6 R14 R17
    assign hs_running = crystal_osc_run | ext_clock_in_en;
    assign ihs_osc_run = ~stop_q; // R19

    // Ticks from stopped sources are ignored
    assign hs_gated = hs_src_tick & hs_running;
    assign ihs_gated = ihs_tick & ihs_osc_run;
    assign sub_gated = sub_tick & ~stop_q;

    // Main clock follows the applied selection, not the requested one
    assign main_req_hs = main_source_choice_q & main_clock_route_q; // R9
    assign main_src_tick = main_hs_q ? hs_gated : ihs_gated; // R9
    assign main_tick = main_src_tick;
    // High-speed main forces the high-speed peripheral clock
    assign periph_tick = (main_source_choice_q | main_hs_q) ?
        hs_gated : ihs_gated; // R9 R10

    // Prescaler for the CPU path from the main clock
    hscc_div #(
        .CNT_W(4)
    ) u_div (
        .clk(clk),
        .rst(rst),
        .tick_in(main_src_tick),
        .ratio(cpu_divide_q),
        .tick_out(div_tick)
    ); // R11 R12

    assign cpu_tick = cpu_sub_q ? sub_gated : div_tick; // R11 R20
    assign cpu_on_highspeed_flag = main_hs_q; // R13
    assign cpu_on_subsystem_flag = cpu_sub_q; // R13
    assign stabilization_time_choice = stab_sel_q;
    assign stop_mode = stop_q;

    // Stop mode entry and release; entry wins a tie
    always @(posedge clk)
    begin
        if (rst)
        begin
            stop_q <= 1'b0;
        end
        else if (stop_exec)
        begin
            stop_q <= 1'b1; // R14
        end
        else if (stop_release)
        begin
            stop_q <= 1'b0;
        end
    end

    // Switch main source only on a tick of the new source; the old one has
    // finished its last pulse, so nothing downstream sees a short period
    always @(posedge clk)
    begin
        if (rst)
        begin
            main_hs_q <= 1'b0; // R19
        end
        else if (main_req_hs && !main_hs_q && hs_gated)
        begin
            main_hs_q <= 1'b1; // R21
        end
        else if (!main_req_hs && main_hs_q && ihs_gated)
        begin
            main_hs_q <= 1'b0; // R21
        end
    end

    // CPU source switch waits for the new source to pulse as well
    always @(posedge clk)
    begin
        if (rst)
        begin
            cpu_sub_q <= 1'b0; // R19
        end
        else if (cpu_source_choice_q && !cpu_sub_q && sub_gated)
        begin
            cpu_sub_q <= 1'b1; // R20 R21
        end
        else if (!cpu_source_choice_q && cpu_sub_q && div_tick)
        begin
            cpu_sub_q <= 1'b0; // R11 R21
        end
    end

    // Write channel: address and data taken in either order
    assign s_axi_awready = ~aw_got_q & ~bvalid_q;
    assign s_axi_wready = ~w_got_q & ~bvalid_q;
    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign do_write = aw_got_q & w_got_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Decoded write target is legal
    assign wr_ok = (awaddr_q == `HSCC_OFF_PIN_CTRL) ||
        (awaddr_q == `HSCC_OFF_OSC_CTRL) ||
        (awaddr_q == `HSCC_OFF_MAIN_SEL) ||
        (awaddr_q == `HSCC_OFF_PROC_CLK) ||
        (awaddr_q == `HSCC_OFF_STAB_CNT) ||
        (awaddr_q == `HSCC_OFF_STAB_SEL);
    assign wr_div = wdata_q[`HSCC_DIV_MSB:`HSCC_DIV_LSB];

    // Capture address and data, then answer one cycle after both are in
    always @(posedge clk)
    begin
        if (rst)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `HSCC_RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_hs)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? `HSCC_RESP_OKAY : `HSCC_RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Register writes; every field lives in byte lane 0
    always @(posedge clk)
    begin
        if (rst)
        begin
            crystal_pin_enable_q <= 1'b0; // R1
            external_input_select_q <= 1'b0; // R1
            main_source_halt_q <= `HSCC_RST_MAIN_HALT;
            main_clock_route_q <= 1'b0;
            main_source_choice_q <= 1'b0;
            cpu_divide_q <= `HSCC_RST_DIV; // R12
            cpu_source_choice_q <= 1'b0; // R19
            stab_sel_q <= `HSCC_RST_STAB_SEL;
        end
        else if (do_write && wstrb_q[0])
        begin
            if (awaddr_q == `HSCC_OFF_PIN_CTRL)
            begin
                crystal_pin_enable_q <= wdata_q[`HSCC_BIT_CRYSTAL_PIN_EN];
                external_input_select_q <= wdata_q[`HSCC_BIT_EXT_INPUT_SEL];
            end
            else if (awaddr_q == `HSCC_OFF_OSC_CTRL)
            begin
                main_source_halt_q <=
                    wdata_q[`HSCC_BIT_MAIN_HALT]; // R5 R6 R17
            end
            else if (awaddr_q == `HSCC_OFF_MAIN_SEL)
            begin
                main_clock_route_q <= wdata_q[`HSCC_BIT_MAIN_ROUTE];
                main_source_choice_q <= wdata_q[`HSCC_BIT_MAIN_CHOICE];
            end
            else if (awaddr_q == `HSCC_OFF_PROC_CLK)
            begin
                // A prohibited code keeps the old ratio
                if (wr_div <= `HSCC_DIV_MAX)
                begin
                    cpu_divide_q <= wr_div; // R12
                end
                cpu_source_choice_q <= wdata_q[`HSCC_BIT_CPU_SOURCE];
            end
            else if (awaddr_q == `HSCC_OFF_STAB_SEL)
            begin
                stab_sel_q <= wdata_q[2:0];
            end
        end
    end

    // Read channel
    assign s_axi_arready = ~rvalid_q;
    assign ar_hs = s_axi_arvalid & s_axi_arready;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Read mux; unused bits read as zero
    always @*
    begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        if ({s_axi_araddr[7:2], 2'b00} == `HSCC_OFF_PIN_CTRL)
        begin
            rd_val[`HSCC_BIT_CRYSTAL_PIN_EN] = crystal_pin_enable_q;
            rd_val[`HSCC_BIT_EXT_INPUT_SEL] = external_input_select_q;
        end
        else if ({s_axi_araddr[7:2], 2'b00} == `HSCC_OFF_OSC_CTRL)
        begin
            rd_val[`HSCC_BIT_MAIN_HALT] = main_source_halt_q;
        end
        else if ({s_axi_araddr[7:2], 2'b00} == `HSCC_OFF_MAIN_SEL)
        begin
            rd_val[`HSCC_BIT_MAIN_ROUTE] = main_clock_route_q;
            rd_val[`HSCC_BIT_MAIN_CHOICE] = main_source_choice_q;
            rd_val[`HSCC_BIT_ON_HIGHSPEED] = main_hs_q; // R13
        end
        else if ({s_axi_araddr[7:2], 2'b00} == `HSCC_OFF_PROC_CLK)
        begin
            rd_val[`HSCC_DIV_MSB:`HSCC_DIV_LSB] = cpu_divide_q;
            rd_val[`HSCC_BIT_CPU_SOURCE] = cpu_source_choice_q;
            rd_val[`HSCC_BIT_ON_SUBSYSTEM] = cpu_sub_q; // R13
        end
        else if ({s_axi_araddr[7:2], 2'b00} == `HSCC_OFF_STAB_CNT)
        begin
            rd_val[7:0] = stabilization_count_status;
        end
        else if ({s_axi_araddr[7:2], 2'b00} == `HSCC_OFF_STAB_SEL)
        begin
            rd_val[2:0] = stab_sel_q;
        end
        else
        begin
            rd_ok = 1'b0;
        end
    end

    // Read data is registered, valid one cycle after the address is taken
    always @(posedge clk)
    begin
        if (rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `HSCC_RESP_OKAY;
        end
        else if (ar_hs)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= rd_ok ? `HSCC_RESP_OKAY : `HSCC_RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end
endmodule // hscc_top

// ### dv/hscc_asserts.sv
// Checker of pin modes, stop gating, status flags and read holding
`timescale 1ns/1ps
module hscc_checker (
    input wire clk,
    input wire rst,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire hs_src_tick,
    input wire sub_tick,
    input wire stop_exec,
    input wire crystal_input_pin_port_en,
    input wire crystal_output_pin_port_en,
    input wire crystal_osc_run,
    input wire ext_clock_in_en,
    input wire ihs_osc_run,
    input wire stop_mode,
    input wire periph_tick,
    input wire cpu_tick,
    input wire cpu_on_highspeed_flag,
    input wire cpu_on_subsystem_flag
);
    // Single clock domain, so clocking and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    pins_reset_a: assert property ($fell(rst) |->
        crystal_input_pin_port_en && crystal_output_pin_port_en &&
        ihs_osc_run && !cpu_on_highspeed_flag && !cpu_on_subsystem_flag)
        else $error("pins or sources wrong after reset");
    xtal_pins_a: assert property (crystal_osc_run |->
        !crystal_input_pin_port_en && !crystal_output_pin_port_en &&
        !ext_clock_in_en)
        else $error("crystal runs while a pin is a port");
    ext_pins_a: assert property (ext_clock_in_en |->
        crystal_input_pin_port_en && !crystal_output_pin_port_en)
        else $error("external input on wrong pin mode");
    stop_halt_a: assert property (stop_exec |=>
        stop_mode && !crystal_osc_run && !ext_clock_in_en && !ihs_osc_run)
        else $error("stop did not halt the sources");
    stop_gate_a: assert property (stop_mode |->
        !cpu_tick && !periph_tick)
        else $error("tick seen in stop mode");
    // Peripheral clock may not fall back while high speed is main
    hs_periph_a: assert property (
        cpu_on_highspeed_flag && periph_tick |-> hs_src_tick)
        else $error("peripheral tick not from high-speed source");
    hs_flag_a: assert property (
        $rose(cpu_on_highspeed_flag) |-> $past(hs_src_tick))
        else $error("high-speed flag rose without a source tick");
    sub_flag_a: assert property (
        $rose(cpu_on_subsystem_flag) |-> $past(sub_tick))
        else $error("subsystem flag rose without a source tick");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before it was taken");
endmodule // hscc_checker

bind hscc_top hscc_checker chk (.clk, .rst, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .hs_src_tick, .sub_tick, .stop_exec,
    .crystal_input_pin_port_en, .crystal_output_pin_port_en,
    .crystal_osc_run, .ext_clock_in_en, .ihs_osc_run, .stop_mode,
    .periph_tick, .cpu_tick, .cpu_on_highspeed_flag, .cpu_on_subsystem_flag);

// ### dv/test_hscc_top.sv
// Self-checking bench of the high-speed clock control
`timescale 1ns/1ps
module test_hscc_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg hs_src_tick = 1'b0, ihs_tick = 1'b0, sub_tick = 1'b0;
    reg stop_exec = 1'b0, stop_release = 1'b0;
    reg [7:0] stabilization_count_status = 8'h5a;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, crystal_input_pin_port_en, crystal_output_pin_port_en;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0] stabilization_time_choice;
    wire crystal_osc_run, ext_clock_in_en, ihs_osc_run, stop_mode, main_tick;
    wire periph_tick, cpu_tick, cpu_on_highspeed_flag, cpu_on_subsystem_flag;
    integer fails = 0, n_tests = 0, cyc = 0, i, g;
    reg [31:0] rdat;
    reg [1:0] rs;
    reg [7:0] a, d, e;
    reg [1:0] r;
    reg [3:0] p;
    // Row: address, write data, read expectation, response, pin modes
    reg [29:0] rows [0:8];

    hscc_top dut (.clk, .rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .hs_src_tick, .ihs_tick, .sub_tick, .stabilization_count_status,
        .stop_exec, .stop_release, .crystal_input_pin_port_en,
        .crystal_output_pin_port_en, .crystal_osc_run, .ext_clock_in_en,
        .ihs_osc_run, .stabilization_time_choice, .stop_mode, .main_tick,
        .periph_tick, .cpu_tick, .cpu_on_highspeed_flag,
        .cpu_on_subsystem_flag);

    initial
    begin
        forever #4 clk = ~clk;
    end

    // Source ticks at coprime rates so each path gives its own spacing
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        ihs_tick <= (cyc % 2 == 0);
        hs_src_tick <= (cyc % 3 == 0);
        sub_tick <= (cyc % 7 == 0);
    end

    task check(input [31:0] seen, input [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    end
    endtask

    task stop_test;
    begin
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    // Write: address and data offered together, each dropped when taken
    task wr(input [7:0] wa, input [31:0] wd);
        reg pa, pw;
    begin
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr <= wa;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (pa || pw)
        begin
            @(posedge clk);
            if (s_axi_awready)
                pa = 1'b0;
            if (s_axi_wready)
                pw = 1'b0;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        while (!s_axi_bvalid)
            @(posedge clk);
        s_axi_bready <= 1'b1;
        @(posedge clk);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    end
    endtask

    // Read: ready raised late on purpose so the answer must stand
    task rd(input [7:0] ra);
    begin
        s_axi_araddr <= ra;
        s_axi_arvalid <= 1'b1;
        @(posedge clk);
        while (!s_axi_arready)
            @(posedge clk);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid)
            @(posedge clk);
        s_axi_rready <= 1'b1;
        @(posedge clk);
        rdat = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    end
    endtask

    // Spacing of CPU ticks; the third gap is past any pending ratio change
    task chk_gap(input integer exp);
    begin
        repeat (3)
        begin
            @(posedge clk);
            while (!cpu_tick)
                @(posedge clk);
            g = 0;
            do
            begin
                @(posedge clk);
                g = g + 1;
            end while (!cpu_tick);
        end
        check(g, exp);
    end
    endtask

    initial
    begin
        #(8 * 30000);
        fails = fails + 1;
        stop_test;
    end

    initial
    begin
        rows[0] = {8'h00, 8'h03, 8'h03, 2'h0, 4'b1000};
        rows[1] = {8'h04, 8'h00, 8'h00, 2'h0, 4'b1001};
        rows[2] = {8'h04, 8'h01, 8'h01, 2'h0, 4'b1000};
        rows[3] = {8'h00, 8'h01, 8'h01, 2'h0, 4'b0000};
        rows[4] = {8'h04, 8'h00, 8'h00, 2'h0, 4'b0010};
        rows[5] = {8'h0c, 8'h05, 8'h01, 2'h0, 4'b0010};
        rows[6] = {8'h14, 8'h02, 8'h02, 2'h0, 4'b0010};
        rows[7] = {8'h10, 8'h00, 8'h5a, 2'h0, 4'b0010};
        rows[8] = {8'h20, 8'h01, 8'h00, 2'h2, 4'b0010};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({crystal_input_pin_port_en, crystal_output_pin_port_en},
            2'h3);
        rd(8'h04);
        check(rdat, 32'h1);
        rd(8'h0c);
        check(rdat, 32'h1);
        rd(8'h08);
        check(rdat, 32'h0);
        for (i = 0; i < 9; i = i + 1)
        begin
            {a, d, e, r, p} = rows[i];
            wr(a, {24'h0, d});
            check(rs, r);
            rd(a);
            check(rs, r);
            if (r == 2'h0)
                check(rdat, e);
            check({crystal_input_pin_port_en, crystal_output_pin_port_en,
                crystal_osc_run, ext_clock_in_en}, p);
        end
        // Main clock is the internal one here, a tick every 2 cycles
        for (i = 0; i < 5; i = i + 1)
        begin
            wr(8'h0c, i);
            chk_gap(2 << i);
        end
        wr(8'h08, 32'h3);
        while (!cpu_on_highspeed_flag)
            @(posedge clk);
        // Main and peripheral clocks both pulse with the high-speed source
        while (!hs_src_tick)
            @(posedge clk);
        check({main_tick, periph_tick}, 2'h3);
        rd(8'h08);
        check(rdat, 32'h7);
        wr(8'h0c, 32'h0);
        chk_gap(3);
        wr(8'h0c, 32'h10);
        while (!cpu_on_subsystem_flag)
            @(posedge clk);
        rd(8'h0c);
        check(rdat, 32'h30);
        chk_gap(7);
        wr(8'h0c, 32'h0);
        while (cpu_on_subsystem_flag)
            @(posedge clk);
        stop_exec <= 1'b1;
        @(posedge clk);
        stop_exec <= 1'b0;
        repeat (20) @(posedge clk);
        check({stop_mode, crystal_osc_run, ihs_osc_run}, 3'h4);
        stop_release <= 1'b1;
        @(posedge clk);
        stop_release <= 1'b0;
        @(posedge clk);
        check({stop_mode, crystal_osc_run, ihs_osc_run}, 3'h3);
        // Leave high speed before halting it, as software must
        wr(8'h08, 32'h0);
        while (cpu_on_highspeed_flag)
            @(posedge clk);
        wr(8'h04, 32'h1);
        check(crystal_osc_run, 1'b0);
        wr(8'h00, 32'h0);
        check({crystal_input_pin_port_en, crystal_output_pin_port_en},
            2'h3);
        // A write with no byte enabled must leave the register alone
        s_axi_wstrb <= 4'h0;
        wr(8'h14, 32'h7);
        s_axi_wstrb <= 4'hf;
        rd(8'h14);
        check(rdat, 32'h2);
        check(stabilization_time_choice, 3'h2);
        // Reset in mid-run must bring back the default ratio and settings
        wr(8'h0c, 32'h3);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h0c);
        check(rdat, 32'h1);
        rd(8'h14);
        check(rdat, 32'h5);
        check(stabilization_time_choice, 3'h5);
        stop_test;
    end
endmodule // test_hscc_top
